// File: src/lsd_defs.svh
`ifndef LSD_DEFS_SVH
`define LSD_DEFS_SVH
// Register indices; byte address is four times the index
`define LSD_IDX_DATA0 2'h0
`define LSD_IDX_DATA1 2'h1
`define LSD_IDX_DATA2 2'h2
`define LSD_IDX_CTRL 2'h3
`define LSD_IO_LAST 12'h00C
`define LSD_ID_BASE 12'h100
`define LSD_ID_COUNT 4'hC
`define LSD_ZERO16 16'h0000
`define LSD_ZERO8 8'h00
`define LSD_ZERO40 40'h00_0000_0000
`define LSD_EN_RST 5'h00
`define LSD_EN_W 5
`define LSD_BITS 6'h28
`define LSD_DIV_ONE 8'h01
`define LSD_STRB_LO 4'h1
`define LSD_STRB_HI 4'h2
`define LSD_STRB_W 4'h3
`define LSD_ID_I 8'h49
`define LSD_ID_P 8'h50
`define LSD_ID_A 8'h41
`define LSD_ID_C 8'h43
`define LSD_ID_REV 8'h30
`define LSD_ID_NBYTES 8'h0C
`endif

// File: src/lsd_pkg.sv
package lsd_pkg;
   typedef enum logic [1:0] {
      LSD_IDLE = 2'b00,
      LSD_LOW = 2'b01,
      LSD_HIGH = 2'b10,
      LSD_LATCH = 2'b11
   } lsd_state_t;
   typedef struct packed {
      logic sclk;
      logic sdata;
      logic strobe;
   } lsd_drv_t;
endpackage : lsd_pkg

// File: src/lsd_ctrl.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lsd_defs.svh"
// Function
// RULE_01 - Five byte ports, paired into three 16-bit words, one per byte lane.
// RULE_02 - Every port register reads back its last written value.
// RULE_03 - Byte writes to either lane and full 16-bit writes are accepted.
// RULE_04 - Reads always return the full 16-bit word.
// RULE_05 - Read data driven only during a read of that location, else zero.
// RULE_06 - Locations 0 and 1 accept a byte write on either lane.
// RULE_07 - Locations 2 and 3 accept byte writes on the low lane only.
// RULE_08 - Full-word writes accepted at all four locations.
// RULE_09 - Control register holds one output enable bit per port.
// RULE_10 - Enable bits clear to zero after reset, outputs disabled.
// RULE_11 - A channel sinks only when its data bit and port enable are one.
// RULE_12 - Port bytes are serialised with clock, strobe and enable for drivers.
// RULE_13 - Any valid data port write starts an update of all five ports.
// RULE_14 - ID reads give fixed bytes on the low lane, upper lane zero.
// RULE_15 - No wait cycles on any transfer; exactly four register locations.
// RULE_16 - Only fully decoded register and ID addresses are answered normally.
// RULE_17 - Held transfers are stretched and completed correctly.
// RULE_18 - Transfer type and strobes decode into write strobes and read enable.
// RULE_19 - No DMA, no interrupts, no memory space.
// RULE_20 - No access accepted or answered during reset.
// RULE_21 - Unsupported transfers get no normal acknowledge.
// RULE_22 - All registers reset to zero.
// RULE_23 - Port four sits in the low lane of location 2; upper lane reads zero.
// RULE_24 - Each update shifts forty bits then pulses the latch strobe once.
module lsd_ctrl #(
   parameter int ADDR_W = 12,
   parameter int SCLK_HALF = 2,
   parameter logic [7:0] MFR_ID = 8'hA5,    // Arbitrary value
   parameter logic [7:0] MODEL_ID = 8'h3C,  // Arbitrary value
   parameter logic [7:0] ID_CRC = 8'h60
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready_ff,
   output logic [31:0] prdata_ff,
   output logic pslverr_ff,
   output lsd_pkg::lsd_drv_t drv_ff,
   output logic [4:0] port_en_ff,
   output logic [39:0] chan_on_ff
);

   // Nine address bits are the least that still reach the ID space
   if (ADDR_W < 9 || ADDR_W > 16 || SCLK_HALF < 1 || SCLK_HALF > 255) begin : g_bad_param
      $error("lsd_ctrl: unsupported parameter value");
   end

   localparam logic [7:0] HALF = 8'(SCLK_HALF);

   logic [7:0] port_ff [5];
   logic [39:0] shift_ff;
   logic [39:0] latched_ff;
   logic [5:0] bit_cnt_ff;
   logic [7:0] div_ff;
   logic upd_req_ff;
   lsd_pkg::lsd_state_t state_ff;
   lsd_pkg::lsd_state_t nxt_state;

   // Whether a write with these strobes is legal at a register location
   function automatic logic wr_legal(input logic [1:0] idx, input logic [3:0] strb);
      logic ok;
      ok = 1'b0;
      if (idx == `LSD_IDX_DATA0 || idx == `LSD_IDX_DATA1) begin
         ok = (strb == `LSD_STRB_LO) || (strb == `LSD_STRB_HI) || (strb == `LSD_STRB_W); // RULE_06
      end else begin
         ok = (strb == `LSD_STRB_LO) || (strb == `LSD_STRB_W); // RULE_07
      end
      return ok;
   endfunction : wr_legal

   function automatic logic [7:0] id_byte(input logic [3:0] idx);
      logic [7:0] b;
      b = `LSD_ZERO8;
      case (idx)
         4'h0: b = `LSD_ID_I;
         4'h1: b = `LSD_ID_P;
         4'h2: b = `LSD_ID_A;
         4'h3: b = `LSD_ID_C;
         4'h4: b = MFR_ID;
         4'h5: b = MODEL_ID;
         4'h6: b = `LSD_ID_REV;
         4'hA: b = `LSD_ID_NBYTES;
         4'hB: b = ID_CRC;
         default: b = `LSD_ZERO8;
      endcase
      return b;
   endfunction : id_byte

   // Address decode; the full address is compared so aliases never answer
   logic io_hit;
   logic id_hit;
   logic [1:0] io_idx;
   logic [3:0] id_idx;
   logic [ADDR_W-1:0] id_off;
   assign io_hit = (paddr < ADDR_W'(`LSD_IO_LAST + 12'h004)) && (paddr[1:0] == 2'b00); // RULE_16
   assign id_off = paddr - ADDR_W'(`LSD_ID_BASE);
   assign id_hit = (paddr >= ADDR_W'(`LSD_ID_BASE)) && (paddr[1:0] == 2'b00)
                   && (id_off[ADDR_W-1:2] < (ADDR_W-2)'(`LSD_ID_COUNT)); // RULE_16
   assign io_idx = paddr[3:2];
   assign id_idx = id_off[5:2];

   logic setup;
   logic access_done;
   logic req_ok;
   logic wr_take;
   assign setup = psel && !penable;
   // Writes to ID space and byte lanes above bit 15 are never legal
   assign req_ok = pwrite ? (io_hit && wr_legal(io_idx, pstrb)) : (io_hit || id_hit); // RULE_21
   assign access_done = psel && penable && pready_ff;
   assign wr_take = access_done && pwrite && req_ok; // RULE_18

   // Answer is registered in the setup cycle, so the access phase never waits
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready_ff <= 1'b0; // RULE_20
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff <= setup; // RULE_15 RULE_17
         pslverr_ff <= setup && !req_ok; // RULE_21 RULE_19
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         prdata_ff <= {`LSD_ZERO16, `LSD_ZERO16};
      end else if (ce) begin
         prdata_ff <= {`LSD_ZERO16, `LSD_ZERO16}; // RULE_05
         if (setup && !pwrite && io_hit) begin
            unique case (io_idx) // RULE_04
               `LSD_IDX_DATA0: prdata_ff[15:0] <= {port_ff[1], port_ff[0]}; // RULE_02
               `LSD_IDX_DATA1: prdata_ff[15:0] <= {port_ff[3], port_ff[2]};
               `LSD_IDX_DATA2: prdata_ff[15:0] <= {`LSD_ZERO8, port_ff[4]}; // RULE_23
               `LSD_IDX_CTRL: prdata_ff[15:0] <= {11'h000, port_en_ff};
            endcase
         end else if (setup && !pwrite && id_hit) begin
            prdata_ff[15:0] <= {`LSD_ZERO8, id_byte(id_idx)}; // RULE_14
         end
      end
   end

   // Port data registers; a byte write leaves the other lane untouched
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 5; i++) begin
            port_ff[i] <= `LSD_ZERO8; // RULE_22
         end
      end else if (ce && wr_take) begin
         unique case (io_idx) // RULE_01 RULE_03 RULE_08
            `LSD_IDX_DATA0: begin
               if (pstrb[0]) port_ff[0] <= pwdata[7:0];
               if (pstrb[1]) port_ff[1] <= pwdata[15:8];
            end
            `LSD_IDX_DATA1: begin
               if (pstrb[0]) port_ff[2] <= pwdata[7:0];
               if (pstrb[1]) port_ff[3] <= pwdata[15:8];
            end
            `LSD_IDX_DATA2: port_ff[4] <= pwdata[7:0]; // RULE_23
            `LSD_IDX_CTRL: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         port_en_ff <= `LSD_EN_RST; // RULE_10
      end else if (ce && wr_take && io_idx == `LSD_IDX_CTRL) begin
         port_en_ff <= pwdata[`LSD_EN_W-1:0]; // RULE_09
      end
   end

   // A write during a running shift is held and replayed, so it is never lost
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         upd_req_ff <= 1'b0;
      end else if (ce) begin
         if (wr_take && io_idx != `LSD_IDX_CTRL) begin
            upd_req_ff <= 1'b1; // RULE_13
         end else if (state_ff == lsd_pkg::LSD_IDLE) begin
            upd_req_ff <= 1'b0;
         end
      end
   end

   logic div_end;
   assign div_end = (div_ff == `LSD_DIV_ONE);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         lsd_pkg::LSD_IDLE: if (upd_req_ff) nxt_state = lsd_pkg::LSD_LOW;
         lsd_pkg::LSD_LOW: if (div_end) nxt_state = lsd_pkg::LSD_HIGH;
         lsd_pkg::LSD_HIGH: begin
            if (div_end) begin
               nxt_state = (bit_cnt_ff == 6'h01) ? lsd_pkg::LSD_LATCH : lsd_pkg::LSD_LOW;
            end
         end
         lsd_pkg::LSD_LATCH: if (div_end) nxt_state = lsd_pkg::LSD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_ff <= lsd_pkg::LSD_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_ff <= `LSD_DIV_ONE;
      end else if (ce) begin
         if (state_ff == lsd_pkg::LSD_IDLE || div_end) begin
            div_ff <= HALF;
         end else begin
            div_ff <= div_ff - `LSD_DIV_ONE;
         end
      end
   end

   // Shift register: port 4 bit 7 leaves first, port 0 bit 0 last
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         shift_ff <= `LSD_ZERO40;
         bit_cnt_ff <= 6'h00;
      end else if (ce) begin
         if (state_ff == lsd_pkg::LSD_IDLE && upd_req_ff) begin
            shift_ff <= {port_ff[4], port_ff[3], port_ff[2], port_ff[1], port_ff[0]}; // RULE_12
            bit_cnt_ff <= `LSD_BITS; // RULE_24
         end else if (state_ff == lsd_pkg::LSD_HIGH && div_end) begin
            shift_ff <= {shift_ff[38:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff - 6'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         drv_ff <= '0;
      end else if (ce) begin
         drv_ff.sclk <= (nxt_state == lsd_pkg::LSD_HIGH); // RULE_12
         // Next bit appears only as sclk falls, so data is steady while sclk is high
         drv_ff.sdata <= (nxt_state == lsd_pkg::LSD_LOW || nxt_state == lsd_pkg::LSD_HIGH)
                         ? ((state_ff == lsd_pkg::LSD_IDLE) ? port_ff[4][7] :
                            (state_ff == lsd_pkg::LSD_HIGH && div_end) ? shift_ff[38] :
                            shift_ff[39])
                         : 1'b0;
         drv_ff.strobe <= (nxt_state == lsd_pkg::LSD_LATCH); // RULE_24
      end
   end

   // Mirror of what the external latches hold, gated by the port enables
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         latched_ff <= `LSD_ZERO40;
         chan_on_ff <= `LSD_ZERO40;
      end else if (ce) begin
         if (state_ff == lsd_pkg::LSD_LATCH && div_end) begin
            latched_ff <= {port_ff[4], port_ff[3], port_ff[2], port_ff[1], port_ff[0]};
         end
         for (int p = 0; p < 5; p++) begin
            chan_on_ff[p*8 +: 8] <= latched_ff[p*8 +: 8] & {8{port_en_ff[p]}}; // RULE_11
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_ready_nowait: assert property (psel && !penable && ce |=> pready_ff) // RULE_15
      else $error("setup cycle not answered in the next cycle");
   a_ready_once: assert property (pready_ff && ce |=> !pready_ff) // RULE_15
      else $error("answer held beyond one cycle");
   a_err_unmapped: assert property (psel && !penable && ce && !io_hit && !id_hit // RULE_21
                                     |=> pslverr_ff)
      else $error("unmapped address answered without error");
   a_err_with_ready: assert property (pslverr_ff |-> pready_ff) // RULE_21
      else $error("error flag without an answer");
   a_err_no_effect: assert property (access_done && ce && pwrite && !req_ok // RULE_21
                                      |=> $stable(port_en_ff) && $stable(port_ff[4]))
      else $error("refused write changed a register");
   a_id_upper_zero: assert property (psel && !penable && ce && !pwrite && id_hit // RULE_14
                                      |=> prdata_ff[31:8] == 24'h000000)
      else $error("ID read drives upper lanes");
   a_rd_idle_zero: assert property (!(psel && !penable) && ce // RULE_05
                                     |=> prdata_ff == 32'h0000_0000)
      else $error("read data driven outside a read");
   a_p4_upper_zero: assert property (psel && !penable && ce && !pwrite && io_hit // RULE_23
                                      && io_idx == `LSD_IDX_DATA2
                                      |=> prdata_ff[15:8] == 8'h00)
      else $error("port four upper lane not zero");
   a_p4_write: assert property (wr_take && ce && io_idx == `LSD_IDX_DATA2 // RULE_23
                                 |=> port_ff[4] == $past(pwdata[7:0]))
      else $error("port four write not taken from the low lane");
   a_hi_lane_keep: assert property (wr_take && ce && io_idx == `LSD_IDX_DATA0 // RULE_03
                                     && pstrb == `LSD_STRB_LO
                                     |=> $stable(port_ff[1]))
      else $error("byte write changed the other lane");
   a_bad_strobe: assert property (wr_take |-> !(io_idx[1] && pstrb == `LSD_STRB_HI)) // RULE_07
      else $error("high lane byte write taken at location 2 or 3");
   a_en_write: assert property (wr_take && ce && io_idx == `LSD_IDX_CTRL // RULE_09
                                 |=> port_en_ff == $past(pwdata[`LSD_EN_W-1:0]))
      else $error("enable write not taken");
   a_update_start: assert property (wr_take && ce && io_idx != `LSD_IDX_CTRL // RULE_13
                                     |=> upd_req_ff || state_ff != lsd_pkg::LSD_IDLE)
      else $error("data write did not start an update");
   a_sdata_steady: assert property (drv_ff.sclk && $past(drv_ff.sclk) // RULE_12
                                     |-> $stable(drv_ff.sdata))
      else $error("serial data moved while the serial clock was high");
   a_strobe_after: assert property ($rose(drv_ff.strobe) |-> $past(bit_cnt_ff) == 6'h01) // RULE_24
      else $error("latch strobe before forty bits shifted");
   a_chan_gate: assert property (ce && $past(ce) && chan_on_ff[7:0] != 8'h00 // RULE_11
                                  |-> $past(port_en_ff[0]))
      else $error("channel on while its port is disabled");
   a_en_clear: assert property ($fell(sys_rst) // RULE_10
                                 |-> port_en_ff == `LSD_EN_RST && chan_on_ff == `LSD_ZERO40)
      else $error("enables or channels not cleared by reset");
   a_port_clear: assert property ($fell(sys_rst) // RULE_22
                                   |-> {port_ff[4], port_ff[3], port_ff[2], port_ff[1],
                                        port_ff[0]} == `LSD_ZERO40)
      else $error("port data not cleared by reset");
   // Reset itself is the trigger here, so the default disable must not mask it
   a_rst_quiet: assert property (@(posedge core_clk) disable iff (1'b0) sys_rst // RULE_20
                                  |=> !pready_ff && !pslverr_ff)
      else $error("answer given during reset");

   c_word_write: cover property (wr_take && pstrb == `LSD_STRB_W);
   c_id_read: cover property (access_done && !pwrite && id_hit);
   c_full_update: cover property (drv_ff.strobe ##1 !drv_ff.strobe);
   c_err_answer: cover property (access_done && pslverr_ff);
   c_frozen_shift: cover property (!ce && state_ff != lsd_pkg::LSD_IDLE);

endmodule : lsd_ctrl

// File: tb/lsd_drv_model.sv
`timescale 1ns/1ps
// Serial latched driver chain: five 8-bit stages cascaded, 40 bits in all
module lsd_drv_model (
   input wire logic core_clk,
   input wire lsd_pkg::lsd_drv_t drv,
   output logic [39:0] latched
);
   logic [39:0] chain;
   logic sclk_q;
   logic strobe_q;
   initial begin
      chain = 40'h00_0000_0000;
      latched = 40'h00_0000_0000;
      sclk_q = 1'b0;
      strobe_q = 1'b0;
   end
   // Drive levels are registered, so edges are seen one system clock late
   always @(posedge core_clk) begin
      if (drv.sclk && !sclk_q) begin
         chain <= {chain[38:0], drv.sdata};
      end
      if (drv.strobe && !strobe_q) begin
         latched <= chain;
      end
      sclk_q <= drv.sclk;
      strobe_q <= drv.strobe;
   end
endmodule : lsd_drv_model

// File: tb/ip_bus_lowside_driver_ctrl_tb.sv
`timescale 1ns/1ps
module ip_bus_lowside_driver_ctrl_tb;
   localparam int HALF = 1;
   // Current shift plus one held update, from the serial timing
   localparam int UPD = 2 * (80 * HALF + HALF + 2) + 10;
   logic core_clk, sys_rst, ce, psel, penable, pwrite, pready_ff, pslverr_ff, err;
   lsd_pkg::lsd_drv_t held;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata_ff, rd;
   logic [3:0] pstrb;
   lsd_pkg::lsd_drv_t drv_ff;
   logic [4:0] port_en_ff;
   logic [39:0] chan_on_ff, latched;
   int fails, checks_done, cycles;
   // Entries: address, data, strobes, refusal expected
   logic [48:0] wt [10] = '{{12'h000, 32'h0000_1111, 4'h3, 1'b0},
      {12'h000, 32'h0000_AA34, 4'h1, 1'b0}, {12'h000, 32'h0000_12BB, 4'h2, 1'b0},
      {12'h004, 32'h0000_0056, 4'h1, 1'b0}, {12'h004, 32'h0000_7800, 4'h2, 1'b0},
      {12'h008, 32'h0000_AB9A, 4'h3, 1'b0}, {12'h008, 32'h0000_0100, 4'h2, 1'b1},
      {12'h008, 32'h0000_11C3, 4'h1, 1'b0}, {12'h010, 32'h0000_0001, 4'h3, 1'b1},
      {12'h100, 32'h0000_0001, 4'h3, 1'b1}};
   logic [48:0] rt [8] = '{{12'h000, 32'h0000_1234, 4'h0, 1'b0},
      {12'h004, 32'h0000_7856, 4'h0, 1'b0}, {12'h008, 32'h0000_00C3, 4'h0, 1'b0},
      {12'h00C, 32'h0000_0000, 4'h0, 1'b0}, {12'h100, 32'h0000_0049, 4'h0, 1'b0},
      {12'h104, 32'h0000_0050, 4'h0, 1'b0}, {12'h118, 32'h0000_0030, 4'h0, 1'b0},
      {12'h010, 32'h0000_0000, 4'h0, 1'b1}};

   lsd_ctrl #(.SCLK_HALF(HALF)) i_lsd_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready_ff(pready_ff), .prdata_ff(prdata_ff),
      .pslverr_ff(pslverr_ff), .drv_ff(drv_ff), .port_en_ff(port_en_ff),
      .chan_on_ff(chan_on_ff));
   lsd_drv_model i_lsd_drv_model (.core_clk(core_clk), .drv(drv_ff), .latched(latched));

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      if (fails == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize

   // One APB transfer; waits on pready, then checks that it came one cycle into the access phase
   task automatic xfer(input logic wr, input logic [48:0] e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= e[48:37];
      pwdata <= e[36:5];
      pstrb <= e[4:1];
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready_ff !== 1'b1);
      rd = prdata_ff;
      err = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n, 1);
      chk(err, e[0]);
   endtask : xfer

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 5000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      fails = 0;
      checks_done = 0;
      cycles = 0;
      sys_rst = 1'b1;
      ce = 1'b1;
      psel = 1'b1;
      penable = 1'b1;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      // Requests presented in reset must go unanswered
      repeat (4) @(posedge core_clk);
      chk(pready_ff, 1'b0);
      sys_rst <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, {12'(4 * i), 32'h0000_0000, 4'h0, 1'b0});
         chk(rd, 32'h0000_0000);
      end
      chk(port_en_ff, 5'h00);
      for (int i = 0; i < 10; i++) begin
         xfer(1'b1, wt[i]);
      end
      for (int i = 0; i < 8; i++) begin
         xfer(1'b0, rt[i]);
         chk(rd, rt[i][36:5]);
      end
      repeat (UPD) @(posedge core_clk);
      chk(latched, 40'hC3_7856_1234);
      chk(chan_on_ff, 40'h00_0000_0000);
      xfer(1'b1, {12'h00C, 32'h0000_0015, 4'h3, 1'b0});
      xfer(1'b1, {12'h00C, 32'h0000_FF05, 4'h1, 1'b0});
      xfer(1'b0, {12'h00C, 32'h0000_0000, 4'h0, 1'b0});
      chk(rd, 32'h0000_0005);
      chk(port_en_ff, 5'h05);
      repeat (2) @(posedge core_clk);
      chk(chan_on_ff, 40'h00_0056_0034);
      chk(latched, 40'hC3_7856_1234);
      // Freeze mid-shift: the driver pins must hold still while ce is low
      xfer(1'b1, {12'h000, 32'h0000_00FF, 4'h1, 1'b0});
      repeat (10) @(posedge core_clk);
      ce <= 1'b0;
      @(posedge core_clk);
      held = drv_ff;
      repeat (4) @(posedge core_clk);
      chk(drv_ff, held);
      ce <= 1'b1;
      repeat (100) @(posedge core_clk);
      chk(latched, 40'hC3_7856_12FF);
      chk(chan_on_ff, 40'h00_0056_00FF);
      // Second reset in mid-run clears enables and data again
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      chk(port_en_ff, 5'h00);
      xfer(1'b0, {12'h000, 32'h0000_0000, 4'h0, 1'b0});
      chk(rd, 32'h0000_0000);
      summarize();
   end
endmodule : ip_bus_lowside_driver_ctrl_tb
